// ===== inc/sbst_pkg.sv
package sbst_pkg;

  // =====================================================================
  // register sizes
  localparam int IR_LEN  = 3;
  localparam int ID_LEN  = 32;
  localparam int BSR_LEN = 76;

  // =====================================================================
  // instruction codes
  localparam logic [2:0] INSTR_EXTEST   = 3'h0;
  localparam logic [2:0] INSTR_IDCODE   = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_BYPASS_A = 3'h3;
  localparam logic [2:0] INSTR_SAMPLE   = 3'h4;
  localparam logic [2:0] INSTR_RESERVED = 3'h5;
  localparam logic [2:0] INSTR_BYPASS_B = 3'h6;
  localparam logic [2:0] INSTR_BYPASS_C = 3'h7;

  // pattern loaded into the instruction shifter on capture
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;

  // =====================================================================
  // identification word layout
  localparam int ID_REV_MSB    = 31;
  localparam int ID_REV_LSB    = 28;
  localparam int ID_DEPTH_MSB  = 27;
  localparam int ID_DEPTH_LSB  = 23;
  localparam int ID_WIDTH_MSB  = 22;
  localparam int ID_WIDTH_LSB  = 18;
  localparam int ID_DEV_MSB    = 17;
  localparam int ID_DEV_LSB    = 12;
  localparam int ID_MANUF_MSB  = 11;
  localparam int ID_MANUF_LSB  = 1;
  localparam int ID_PRESENT    = 0;
  localparam logic ID_PRESENT_VAL = 1'b1;

  // =====================================================================
  // boundary chain: index = chain bit number - 1, index 75 faces tdi
  localparam int BSR_POS_ADDR0       = 75;
  localparam int BSR_POS_ADDR1       = 74;
  localparam int BSR_POS_BURST_ORDER = 69;
  localparam int BSR_POS_PARITY_HI   = 63;
  localparam int BSR_POS_PARITY_LO   = 23;
  localparam int BSR_POS_SLEEP       = 9;
  // unconnected positions, captured as zero
  localparam logic [75:0] BSR_NC_MASK = 76'h00f007f0a002f007d01;
  localparam logic [75:0] BSR_RESET   = 76'h00000000000000000000;

  // =====================================================================
  // controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } sbst_state_t;

  // =====================================================================
  // instruction decoding
  function automatic logic sel_bsr(input logic [2:0] ir);
    return (ir == INSTR_EXTEST) || (ir == INSTR_SAMPLE_Z) ||
           (ir == INSTR_SAMPLE);
  endfunction

  function automatic logic sel_hiz(input logic [2:0] ir);
    return (ir == INSTR_EXTEST) || (ir == INSTR_SAMPLE_Z);
  endfunction

  function automatic logic sel_id(input logic [2:0] ir);
    return ir == INSTR_IDCODE;
  endfunction

endpackage

// ===== inc/sbst_ctl_if.sv
`timescale 1ns/1ps
interface sbst_ctl_if;
  logic tck_rise;
  logic tms;
  logic tdi;
  logic tlr;
  logic capture_dr;
  logic shift_dr;
  logic update_dr;
  logic capture_ir;
  logic shift_ir;
  logic update_ir;
  logic bsr_sel;
  logic bsr_serial;

  modport fsm (
    input  tck_rise, tms,
    output tlr, capture_dr, shift_dr, update_dr,
    output capture_ir, shift_ir, update_ir
  );

  modport core (
    output tck_rise, tms, tdi, bsr_sel,
    input  tlr, capture_dr, shift_dr, update_dr,
    input  capture_ir, shift_ir, update_ir, bsr_serial
  );

  modport bsr (
    input  tck_rise, tdi, capture_dr, shift_dr, bsr_sel,
    output bsr_serial
  );
endinterface

// ===== logic/sbst_tap_fsm.sv
`timescale 1ns/1ps
module sbst_tap_fsm (
  input  wire logic  clk,
  input  wire logic  resetn,
  sbst_ctl_if.fsm    ctl
);

  sbst_pkg::sbst_state_t state;
  sbst_pkg::sbst_state_t next_state;

  // =====================================================================
  // state sequence
  // (R16) advance on tck rise
  always_comb begin
    next_state = state;
    if (ctl.tck_rise) begin
      case (state)
        sbst_pkg::ST_RESET:
          next_state = ctl.tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
        sbst_pkg::ST_IDLE:
          next_state = ctl.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
        sbst_pkg::ST_SEL_DR:
          next_state = ctl.tms ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
        sbst_pkg::ST_CAP_DR:
          next_state = ctl.tms ? sbst_pkg::ST_EXIT1_DR
                               : sbst_pkg::ST_SHIFT_DR;
        sbst_pkg::ST_SHIFT_DR:
          next_state = ctl.tms ? sbst_pkg::ST_EXIT1_DR
                               : sbst_pkg::ST_SHIFT_DR;
        sbst_pkg::ST_EXIT1_DR:
          next_state = ctl.tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PAUSE_DR;
        sbst_pkg::ST_PAUSE_DR:
          next_state = ctl.tms ? sbst_pkg::ST_EXIT2_DR
                               : sbst_pkg::ST_PAUSE_DR;
        sbst_pkg::ST_EXIT2_DR:
          next_state = ctl.tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SHIFT_DR;
        sbst_pkg::ST_UPD_DR:
          next_state = ctl.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
        sbst_pkg::ST_SEL_IR:
          next_state = ctl.tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_CAP_IR;
        sbst_pkg::ST_CAP_IR:
          next_state = ctl.tms ? sbst_pkg::ST_EXIT1_IR
                               : sbst_pkg::ST_SHIFT_IR;
        sbst_pkg::ST_SHIFT_IR:
          next_state = ctl.tms ? sbst_pkg::ST_EXIT1_IR
                               : sbst_pkg::ST_SHIFT_IR;
        sbst_pkg::ST_EXIT1_IR:
          next_state = ctl.tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PAUSE_IR;
        sbst_pkg::ST_PAUSE_IR:
          next_state = ctl.tms ? sbst_pkg::ST_EXIT2_IR
                               : sbst_pkg::ST_PAUSE_IR;
        sbst_pkg::ST_EXIT2_IR:
          next_state = ctl.tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SHIFT_IR;
        sbst_pkg::ST_UPD_IR:
          next_state = ctl.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
        default:
          next_state = sbst_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= sbst_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // state flags
  always_comb begin
    ctl.tlr        = state == sbst_pkg::ST_RESET;
    ctl.capture_dr = state == sbst_pkg::ST_CAP_DR;
    ctl.shift_dr   = state == sbst_pkg::ST_SHIFT_DR;
    ctl.update_dr  = state == sbst_pkg::ST_UPD_DR;
    ctl.capture_ir = state == sbst_pkg::ST_CAP_IR;
    ctl.shift_ir   = state == sbst_pkg::ST_SHIFT_IR;
    ctl.update_ir  = state == sbst_pkg::ST_UPD_IR;
  end

endmodule

// ===== logic/sbst_bsr.sv
`timescale 1ns/1ps
module sbst_bsr #(
  parameter int BSR_LEN = sbst_pkg::BSR_LEN
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [BSR_LEN-1:0] ring_in,
  sbst_ctl_if.bsr                 ctl
);

  if (BSR_LEN != sbst_pkg::BSR_LEN) begin : g_len_check
    $error("boundary chain length must match the fixed scan order");
  end

  logic [BSR_LEN-1:0] ring_s1;
  logic [BSR_LEN-1:0] ring_s2;
  logic [BSR_LEN-1:0] chain;
  logic [BSR_LEN-1:0] next_chain;

  // =====================================================================
  // ring capture and shift
  always_comb begin
    next_chain = chain;
    if (ctl.tck_rise && ctl.bsr_sel) begin
      // (R12) fixed order, nc zeroed
      if (ctl.capture_dr) begin
        next_chain = ring_s2 & ~sbst_pkg::BSR_NC_MASK;
      // (R15) msb faces tdi
      end else if (ctl.shift_dr) begin
        next_chain = {ctl.tdi, chain[BSR_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ring_s1 <= sbst_pkg::BSR_RESET;
      ring_s2 <= sbst_pkg::BSR_RESET;
      chain   <= sbst_pkg::BSR_RESET;
    end else begin
      ring_s1 <= ring_in;
      ring_s2 <= ring_s1;
      chain   <= next_chain;
    end
  end

  // (R15) lsb faces tdo
  assign ctl.bsr_serial = chain[0];

endmodule

// ===== logic/sbst_tap_top.sv
// Notes on behaviour
// (R1) code 000: capture ring, chain, outputs high-z
// (R2) code 001: identification word on scan path
// (R3) code 010: capture ring, chain, outputs high-z
// (R4) code 100: capture ring, chain, outputs untouched
// (R5) codes 111, 011, 110 select one-bit bypass
// (R6) controller never loads reserved code 101; update loads any shifted code, 101 included, as bypass
// (R7) identification word 32 bits, bit 0 one
// (R8) bits 11:1 hold manufacturer code
// (R9) bits 31:28 hold revision number
// (R10) bits 27:23 depth, 22:18 width
// (R11) bits 17:12 reserved, fixed content
// (R12) boundary chain 76 bits, fixed order
// (R13) instruction preset to identification on reset
// (R14) instruction capture loads low bits 01
// (R15) chain msb at input, lsb at output
// (R16) standard controller, tdo changes on falling
`timescale 1ns/1ps
module sbst_tap_top #(
  parameter logic [3:0]  REVISION    = 4'h1,
  parameter logic [4:0]  DEPTH_CODE  = 5'h01,
  parameter logic [4:0]  WIDTH_CODE  = 5'h01,
  parameter logic [5:0]  DEVICE_CODE = 6'h00,
  // arbitrary value
  parameter logic [10:0] MANUF_CODE  = 11'h2a5
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RESETN,
  input  wire logic                          TCK,
  input  wire logic                          TMS,
  input  wire logic                          TDI,
  input  wire logic [sbst_pkg::BSR_LEN-1:0]  RING_IN,
  output logic                               TDO,
  output logic                               TDO_OE,
  output logic                               MEM_OUT_HIZ,
  output logic [sbst_pkg::IR_LEN-1:0]        INSTR
);

  if (MANUF_CODE == 11'h000) begin : g_manuf_check
    $error("manufacturer code must not be all zero");
  end

  sbst_ctl_if ctl ();

  // =====================================================================
  // pin synchronisers
  logic tck_s1;
  logic tck_s2;
  logic tck_s3;
  logic tms_s1;
  logic tms_s2;
  logic tdi_s1;
  logic tdi_s2;
  logic next_tck_s1;
  logic next_tck_s2;
  logic next_tck_s3;
  logic next_tms_s1;
  logic next_tms_s2;
  logic next_tdi_s1;
  logic next_tdi_s2;
  logic tck_fall;

  // test clock, third stage only for edge finding
  always_comb begin
    next_tck_s1 = TCK;
    next_tck_s2 = tck_s1;
    next_tck_s3 = tck_s2;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
    end else begin
      tck_s1 <= next_tck_s1;
      tck_s2 <= next_tck_s2;
      tck_s3 <= next_tck_s3;
    end
  end

  // mode select, idles high
  always_comb begin
    next_tms_s1 = TMS;
    next_tms_s2 = tms_s1;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
    end else begin
      tms_s1 <= next_tms_s1;
      tms_s2 <= next_tms_s2;
    end
  end

  // serial input
  always_comb begin
    next_tdi_s1 = TDI;
    next_tdi_s2 = tdi_s1;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
    end else begin
      tdi_s1 <= next_tdi_s1;
      tdi_s2 <= next_tdi_s2;
    end
  end

  // (R16) edges of the sampled test clock
  assign ctl.tck_rise = tck_s2 & ~tck_s3;
  assign tck_fall     = ~tck_s2 & tck_s3;
  assign ctl.tms      = tms_s2;
  assign ctl.tdi      = tdi_s2;

  // =====================================================================
  // controller and boundary chain
  sbst_tap_fsm u_fsm (
    .clk    (CORE_CLK),
    .resetn (RESETN),
    .ctl    (ctl.fsm)
  );

  sbst_bsr #(
    .BSR_LEN (sbst_pkg::BSR_LEN)
  ) u_bsr (
    .clk     (CORE_CLK),
    .resetn  (RESETN),
    .ring_in (RING_IN),
    .ctl     (ctl.bsr)
  );

  // =====================================================================
  // identification word
  logic [sbst_pkg::ID_LEN-1:0] id_word;

  always_comb begin
    id_word = '0;
    // (R9) revision field
    id_word[sbst_pkg::ID_REV_MSB:sbst_pkg::ID_REV_LSB]     = REVISION;
    // (R10) depth and width
    id_word[sbst_pkg::ID_DEPTH_MSB:sbst_pkg::ID_DEPTH_LSB] = DEPTH_CODE;
    id_word[sbst_pkg::ID_WIDTH_MSB:sbst_pkg::ID_WIDTH_LSB] = WIDTH_CODE;
    // (R11) reserved device field
    id_word[sbst_pkg::ID_DEV_MSB:sbst_pkg::ID_DEV_LSB]     = DEVICE_CODE;
    // (R8) manufacturer code
    id_word[sbst_pkg::ID_MANUF_MSB:sbst_pkg::ID_MANUF_LSB] = MANUF_CODE;
    // (R7) presence bit
    id_word[sbst_pkg::ID_PRESENT] = sbst_pkg::ID_PRESENT_VAL;
  end

  // =====================================================================
  // instruction and data registers
  logic [sbst_pkg::IR_LEN-1:0] ir;
  logic [sbst_pkg::IR_LEN-1:0] ir_shift;
  logic [sbst_pkg::ID_LEN-1:0] id_shift;
  logic                        bypass;
  logic [sbst_pkg::IR_LEN-1:0] next_ir;
  logic [sbst_pkg::IR_LEN-1:0] next_ir_shift;
  logic [sbst_pkg::ID_LEN-1:0] next_id_shift;
  logic                        next_bypass;
  logic                        dr_serial;

  // (R1) (R3) (R4) boundary chain selection
  assign ctl.bsr_sel = sbst_pkg::sel_bsr(ir);

  // (R5) bypass for the remaining codes
  always_comb begin
    if (sbst_pkg::sel_bsr(ir)) begin
      dr_serial = ctl.bsr_serial;
    end else if (sbst_pkg::sel_id(ir)) begin
      dr_serial = id_shift[0];
    end else begin
      dr_serial = bypass;
    end
  end

  // =====================================================================
  // instruction register and its shifter
  always_comb begin
    next_ir       = ir;
    next_ir_shift = ir_shift;
    if (ctl.tck_rise) begin
      // (R13) preset in reset state
      if (ctl.tlr) begin
        next_ir = sbst_pkg::INSTR_IDCODE;
      end
      // (R14) capture pattern
      if (ctl.capture_ir) begin
        next_ir_shift = sbst_pkg::IR_CAPTURE_VAL;
      end else if (ctl.shift_ir) begin
        next_ir_shift = {ctl.tdi, ir_shift[sbst_pkg::IR_LEN-1:1]};
      end
      if (ctl.update_ir) begin
        next_ir = ir_shift;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // (R13) preset at power-up
      ir       <= sbst_pkg::INSTR_IDCODE;
      ir_shift <= sbst_pkg::IR_CAPTURE_VAL;
    end else begin
      ir       <= next_ir;
      ir_shift <= next_ir_shift;
    end
  end

  // =====================================================================
  // identification shifter
  always_comb begin
    next_id_shift = id_shift;
    if (ctl.tck_rise && sbst_pkg::sel_id(ir)) begin
      // (R2) load identification word
      if (ctl.capture_dr) begin
        next_id_shift = id_word;
      end else if (ctl.shift_dr) begin
        next_id_shift = {ctl.tdi, id_shift[sbst_pkg::ID_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      id_shift <= '0;
    end else begin
      id_shift <= next_id_shift;
    end
  end

  // =====================================================================
  // bypass cell, captures zero
  always_comb begin
    next_bypass = bypass;
    if (ctl.tck_rise) begin
      if (ctl.capture_dr) begin
        next_bypass = 1'b0;
      end else if (ctl.shift_dr) begin
        next_bypass = ctl.tdi;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bypass <= 1'b0;
    end else begin
      bypass <= next_bypass;
    end
  end

  // =====================================================================
  // serial output and its output enable
  logic next_tdo;
  logic next_tdo_oe;
  logic next_hiz;

  always_comb begin
    next_tdo    = TDO;
    next_tdo_oe = TDO_OE;
    // (R16) tdo changes on falling edge
    if (tck_fall) begin
      next_tdo_oe = ctl.shift_ir | ctl.shift_dr;
      if (ctl.shift_ir) begin
        next_tdo = ir_shift[0];
      end else if (ctl.shift_dr) begin
        next_tdo = dr_serial;
      end else begin
        next_tdo = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      TDO    <= next_tdo;
      TDO_OE <= next_tdo_oe;
    end
  end

  // =====================================================================
  // memory output control and instruction view
  always_comb begin
    // (R1) (R3) high-z for 000 and 010
    next_hiz = sbst_pkg::sel_hiz(ir);
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      MEM_OUT_HIZ <= 1'b0;
      INSTR       <= sbst_pkg::INSTR_IDCODE;
    end else begin
      MEM_OUT_HIZ <= next_hiz;
      INSTR       <= next_ir;
    end
  end

endmodule

// ===== testbench/sbst_tap_assertions.sv
`timescale 1ns/1ps
module sbst_tap_chk (
  input wire logic       CORE_CLK,
  input wire logic       RESETN,
  input wire logic       TCK,
  input wire logic       TDO,
  input wire logic       TDO_OE,
  input wire logic       MEM_OUT_HIZ,
  input wire logic [2:0] INSTR
);
  default clocking dck @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  // ==========
  // output float control
  // code 000 floats
  AST_HIZ_EXTEST: assert property (INSTR == 3'h0 |=> MEM_OUT_HIZ)
    else $error("outputs not floated under code 000");
  AST_HIZ_SAMPZ: assert property (INSTR == 3'h2 |=> MEM_OUT_HIZ)
    else $error("outputs not floated under code 010");
  AST_KEEP_SAMPLE: assert property (INSTR == 3'h4 |=> !MEM_OUT_HIZ)
    else $error("outputs floated under code 100");
  AST_KEEP_BYPASS: assert property (
    INSTR inside {3'h3, 3'h6, 3'h7} |=> !MEM_OUT_HIZ)
    else $error("outputs floated under bypass");
  AST_KEEP_ID: assert property (INSTR == 3'h1 |=> !MEM_OUT_HIZ)
    else $error("outputs floated under code 001");
  AST_RESET_ID: assert property (
    !$past(RESETN) |-> INSTR == 3'h1 && !TDO_OE && !MEM_OUT_HIZ)
    else $error("instruction not preset after reset");
  // ==========
  // link timing
  // serial output moves after falls
  AST_TDO_AT_FALL: assert property (
    $changed(TDO) || $changed(TDO_OE) |-> !$past(TCK, 2))
    else $error("serial output moved outside low phase");
  AST_TDO_STANDS: assert property (
    $rose(TCK) |=> $stable(TDO) [*3])
    else $error("serial output moved while clock high");
  AST_INSTR_AT_RISE: assert property (
    $changed(INSTR) |-> $past(TCK, 2))
    else $error("instruction moved outside high phase");
  cover property (INSTR == 3'h0 && MEM_OUT_HIZ);
  cover property ($rose(TDO_OE));
  cover property (INSTR == 3'h4 && !MEM_OUT_HIZ);
endmodule

bind sbst_tap_top sbst_tap_chk i_chk (
  .CORE_CLK    (CORE_CLK),
  .RESETN      (RESETN),
  .TCK         (TCK),
  .TDO         (TDO),
  .TDO_OE      (TDO_OE),
  .MEM_OUT_HIZ (MEM_OUT_HIZ),
  .INSTR       (INSTR)
);

// ===== testbench/sbst_link_model.sv
`timescale 1ns/1ps
module sbst_link_model (
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ==========
  // link cycles, entered at a falling clk edge
  // inputs move while low
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    q = tdo;
    tck = 1'b1;
    repeat (4) @(negedge clk);
    tck = 1'b0;
  endtask
  task automatic tlr();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
  // released data line toggles outside shifts
  task automatic scan(input logic ir, input int n, input logic [79:0] din,
                      output logic [79:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) begin
      step(1'b1, ~tdi, q);
    end
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule

// ===== testbench/tb_sram_boundary_scan_tap.sv
`timescale 1ns/1ps
module tb_sram_boundary_scan_tap;
  localparam int LIMIT = 40000;
  // arbitrary identification values
  localparam logic [31:0] ID_WORD = {4'h3, 5'h0b, 5'h12, 6'h2d, 11'h1c3, 1'b1};
  localparam logic [2:0] CODES [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  logic        core_clk;
  logic        resetn;
  logic [75:0] ring_in;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic        mem_out_hiz;
  logic [2:0]  instr;
  logic [79:0] din;
  logic [79:0] dout;
  integer      seed;
  int          failures;
  int          check_count;
  int          cycles;
  logic        oe_seen;

  sbst_tap_top #(
    .REVISION    (4'h3),
    .DEPTH_CODE  (5'h0b),
    .WIDTH_CODE  (5'h12),
    .DEVICE_CODE (6'h2d),
    .MANUF_CODE  (11'h1c3)
  ) i_dut (
    .CORE_CLK    (core_clk),
    .RESETN      (resetn),
    .TCK         (tck),
    .TMS         (tms),
    .TDI         (tdi),
    .RING_IN     (ring_in),
    .TDO         (tdo),
    .TDO_OE      (tdo_oe),
    .MEM_OUT_HIZ (mem_out_hiz),
    .INSTR       (instr)
  );
  sbst_link_model i_link (
    .clk (core_clk),
    .tdo (tdo),
    .tck (tck),
    .tms (tms),
    .tdi (tdi)
  );

  // ==========
  // clock, watchdog, checking
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end
  // output enable seen during a data scan
  always @(posedge core_clk) begin
    if (tdo_oe) begin
      oe_seen <= 1'b1;
    end
  end
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========
  // expectations
  function automatic int chain_len(input logic [2:0] c);
    if (c == 3'h0 || c == 3'h2 || c == 3'h4) begin
      return sbst_pkg::BSR_LEN;
    end
    return (c == 3'h1) ? sbst_pkg::ID_LEN : 1;
  endfunction
  // captured chain followed by the first bit fed in
  function automatic logic [79:0] exp_scan(input logic [2:0] c,
                                           input logic [75:0] ring,
                                           input logic d0);
    logic [79:0] e;
    e = '0;
    if (chain_len(c) == 76) begin
      e[75:0] = ring & ~sbst_pkg::BSR_NC_MASK;
    end else if (chain_len(c) == 32) begin
      e[31:0] = ID_WORD;
    end
    e[chain_len(c)] = d0;
    return e;
  endfunction
  task automatic run_code(input logic [2:0] c);
    ring_in = 76'({$random(seed), $random(seed), $random(seed)});
    din = 80'({$random(seed), $random(seed), $random(seed)});
    i_link.scan(1'b1, 3, {77'h0, c}, dout);
    check(dout, 80'h1);
    check(80'(instr), 80'(c));
    check(80'(mem_out_hiz), 80'(c == 3'h0 || c == 3'h2));
    oe_seen = 1'b0;
    i_link.scan(1'b0, chain_len(c) + 1, din, dout);
    check(80'(oe_seen), 80'h1);
    check(dout, exp_scan(c, ring_in, din[0]));
    check(80'(tdo_oe), 80'h0);
  endtask

  // ==========
  // main sequence
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    ring_in = '0;
    seed = 50490;
    failures = 0;
    check_count = 0;
    cycles = 0;
    oe_seen = 1'b0;
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    check(80'({instr, tdo_oe, mem_out_hiz}), 80'h4);
    i_link.tlr();
    din = 80'({$random(seed), $random(seed), $random(seed)});
    i_link.scan(1'b0, 33, din, dout);
    check(dout, exp_scan(3'h1, '0, din[0]));
    foreach (CODES[k]) begin
      run_code(CODES[k]);
    end
    for (int k = 0; k < 4; k++) begin
      run_code(CODES[$unsigned($random(seed)) % 7]);
    end
    // reset in mid-run under a floating code
    run_code(3'h2);
    resetn = 1'b0;
    @(negedge core_clk);
    check(80'({instr, mem_out_hiz}), 80'h2);
    resetn = 1'b1;
    i_link.tlr();
    run_code(3'h0);
    i_link.tlr();
    check(80'({instr, mem_out_hiz}), 80'h2);
    report_and_stop();
  end
endmodule
